// ---- dv/wpla_sha_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// hash engine stand-in: done after LAT cycles, result held until next start
module wpla_sha_model #(
    parameter int LAT = 4
) (
    input  wire logic    clk_sys,
    input  wire logic    rst,
    input  wire logic    sha_start,
    input  wire logic    sha_with_id,
    input  wire logic    fail_req,
    output logic         sha_done,
    output logic         sha_fail,
    output logic [255:0] sha_mac
);
    logic [7:0] cnt_q;
    logic       id_q;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 8'h00;
            id_q <= 1'b0;
            sha_done <= 1'b0;
        end
        else if (sha_start)
        begin
            cnt_q <= 8'(LAT);
            id_q <= sha_with_id;
            sha_done <= 1'b0;
        end
        else if (cnt_q != 8'h00)
        begin
            cnt_q <= cnt_q - 8'h01;
            sha_done <= (cnt_q == 8'h01);
        end
    end
    // failure on request, so the error path gets exercised
    assign sha_fail = fail_req;
    // inverted pattern until done, so a stale read never matches
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            sha_mac[16*i +: 16] = {4'hC, 3'h0, id_q, 4'h0, 4'(i)} ^ {16{~sha_done}};
        end
    end
endmodule
`default_nettype wire

// ---- dv/wpla_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module wpla_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [8:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        page_wr_en,
    input wire logic        override_enable_cfg,
    input wire logic        sha_start,
    input wire logic        sha_with_id,
    input wire logic        discharge_fet_off,
    input wire logic        charge_fet_off
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_en_wr; page_wr_en |-> reg_wr; endproperty
    a_en_wr: assert property (p_en_wr) else $error("write enable without write");
    property p_dis_ovr; discharge_fet_off |-> override_enable_cfg; endproperty
    a_dis_ovr: assert property (p_dis_ovr) else $error("dis off without override");
    property p_chg_ovr; charge_fet_off |-> override_enable_cfg; endproperty
    a_chg_ovr: assert property (p_chg_ovr) else $error("chg off without override");
    property p_dis_hold;
        override_enable_cfg && !(reg_wr && reg_addr == 9'h061) ##1 override_enable_cfg
            |-> $stable(discharge_fet_off);
    endproperty
    a_dis_hold: assert property (p_dis_hold) else $error("dis off moved");
    property p_chg_hold;
        override_enable_cfg && !(reg_wr && reg_addr == 9'h061) ##1 override_enable_cfg
            |-> $stable(charge_fet_off);
    endproperty
    a_chg_hold: assert property (p_chg_hold) else $error("chg off moved");
    property p_start_cause; sha_start |-> $past(reg_wr) && $past(reg_addr) == 9'h060; endproperty
    a_start_cause: assert property (p_start_cause) else $error("start w/o command");
    property p_start_pulse; sha_start |=> !sha_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    property p_start_id; sha_start |-> sha_with_id == ($past(reg_wdata) == 16'h3500); endproperty
    a_start_id: assert property (p_start_id) else $error("id select wrong");
    property p_lock_hi; reg_rd && reg_addr == 9'h07F |=> reg_rdata[15:5] == 11'h000; endproperty
    a_lock_hi: assert property (p_lock_hi) else $error("lock upper bits set");
    property p_stat_hi; reg_rd && reg_addr == 9'h061 |=> reg_rdata[15:10] == 6'h00; endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
endmodule
bind wpla_top wpla_checker u_wpla_checker (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .page_wr_en(page_wr_en), .override_enable_cfg(override_enable_cfg),
    .sha_start(sha_start), .sha_with_id(sha_with_id),
    .discharge_fet_off(discharge_fet_off), .charge_fet_off(charge_fet_off));
`default_nettype wire

// ---- dv/wpla_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module wpla_top_tb;
    import wpla_pkg::*;
    localparam int T_SHA = 10;
    typedef struct packed { logic [15:0] prot; logic [8:0] addr; logic en; } wpla_row_t;
    localparam wpla_row_t ROWS [11] = '{
        '{16'h0008, 9'h1A0, 1'b0}, '{16'h0008, 9'h1E0, 1'b0}, '{16'h0008, 9'h010, 1'b1},
        '{16'h0010, 9'h0D0, 1'b0}, '{16'h0010, 9'h1B0, 1'b1}, '{16'h0020, 9'h190, 1'b0},
        '{16'h0040, 9'h1C0, 1'b0}, '{16'h0080, 9'h1D0, 1'b0}, '{16'h0080, 9'h1C0, 1'b1},
        '{16'h0000, 9'h050, 1'b1}, '{16'h0001, 9'h050, 1'b0}};
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [8:0]   reg_addr = 9'h000;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         override_enable_cfg = 1'b0;
    logic         nv_fail = 1'b0;
    logic         sha_fail_req = 1'b0;
    logic [15:0]  reg_rdata;
    logic         page_wr_en, sha_done, sha_fail, sha_start, sha_with_id;
    logic         discharge_fet_off, charge_fet_off, en_seen;
    logic [255:0] sha_mac;
    logic [15:0]  v;
    int           miscompares = 0;
    int           n_tests = 0;
    wpla_top #(.T_UPDATE_CYC(10), .T_SHA_CYC(T_SHA)) u_wpla_top (.clk_sys(clk_sys), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .page_wr_en(page_wr_en),
        .override_enable_cfg(override_enable_cfg), .nv_fail(nv_fail), .sha_done(sha_done),
        .sha_fail(sha_fail), .sha_mac(sha_mac), .sha_start(sha_start),
        .sha_with_id(sha_with_id), .discharge_fet_off(discharge_fet_off),
        .charge_fet_off(charge_fet_off));
    wpla_sha_model #(.LAT(4)) u_wpla_sha_model (.clk_sys(clk_sys), .rst(rst),
        .sha_start(sha_start), .sha_with_id(sha_with_id), .fail_req(sha_fail_req),
        .sha_done(sha_done), .sha_fail(sha_fail), .sha_mac(sha_mac));
    always #12.5 clk_sys = ~clk_sys;
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        #1 en_seen = page_wr_en;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic dw(input logic [15:0] d);
        wr(9'h061, d);
        wr(9'h061, d);
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // bounded poll on the busy flag
    task automatic wait_idle();
        logic [15:0] s;
        s = 16'h0002;
        for (int i = 0; i < 40 && s[1] !== 1'b0; i++)
            rd(9'h061, s);
        if (s[1] !== 1'b0)
        begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic fets(input logic [1:0] exp);
        chk({14'h0000, discharge_fet_off, charge_fet_off}, {14'h0000, exp});
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(9'h061, v);
        chk(v, 16'h00F9);
        rd(9'h07F, v);
        chk(v, 16'h0000);
        wr(9'h1A0, 16'h1234);
        chk({15'h0, en_seen}, 16'h0000);
        // a read between the two writes must restart the sequence
        wr(9'h061, 16'h0000);
        rd(9'h061, v);
        chk(v, 16'h00F9);
        wr(9'h061, 16'h0000);
        rd(9'h061, v);
        chk(v, 16'h00F9);
        dw(16'h0000);
        rd(9'h061, v);
        chk(v, 16'h0000);
        foreach (ROWS[i])
        begin
            dw(ROWS[i].prot);
            rd(9'h061, v);
            chk(v, ROWS[i].prot);
            wr(ROWS[i].addr, 16'h1234);
            chk({15'h0, en_seen}, {15'h0, ROWS[i].en});
        end
        dw(16'h00F9);
        rd(9'h061, v);
        chk(v, 16'h0001);
        dw(16'h0000);
        dw(16'h0300);
        fets(2'b00);
        @(posedge clk_sys);
        override_enable_cfg <= 1'b1;
        #1 fets(2'b11);
        dw(16'h0100);
        dw(16'h0101);
        dw(16'h0301);
        rd(9'h061, v);
        chk(v, 16'h0101);
        fets(2'b01);
        @(posedge clk_sys);
        override_enable_cfg <= 1'b0;
        #1 fets(2'b00);
        dw(16'h0000);
        wr(9'h061, 16'h0000);
        rd(9'h061, v);
        chk(v, 16'h0000);
        wr(9'h060, 16'h6A05);
        rd(9'h061, v);
        chk(v & 16'h0002, 16'h0002);
        wait_idle();
        rd(9'h07F, v);
        chk(v, 16'h0005);
        rd(9'h061, v);
        chk(v, 16'h0000);
        wr(9'h1A0, 16'h1234);
        chk({15'h0, en_seen}, 16'h0000);
        wr(9'h180, 16'h1234);
        chk({15'h0, en_seen}, 16'h0000);
        wr(9'h010, 16'h1234);
        chk({15'h0, en_seen}, 16'h0001);
        @(posedge clk_sys);
        nv_fail <= 1'b1;
        wr(9'h060, 16'h6A02);
        wait_idle();
        nv_fail <= 1'b0;
        rd(9'h061, v);
        chk(v, 16'h0004);
        rd(9'h07F, v);
        chk(v, 16'h0005);
        wr(9'h07F, 16'h0000);
        rd(9'h07F, v);
        chk(v, 16'h0005);
        wr(9'h061, 16'h0000);
        rd(9'h061, v);
        chk(v, 16'h0000);
        wr(9'h060, 16'h000F);
        wait_idle();
        rd(9'h061, v);
        chk(v, 16'h0004);
        wr(9'h061, 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 10; i++)
                wr(9'h0C0 + 9'(i), 16'hBEE0 + 16'(i));
            rd(9'h0C9, v);
            chk(v, 16'hBEE9);
            wr(9'h060, k[0] ? 16'h3500 : 16'h3600);
            repeat (T_SHA + 4) @(posedge clk_sys);
            wait_idle();
            for (int i = 0; i < 16; i++)
            begin
                rd(9'h0C0 + 9'(i), v);
                chk(v, {4'hC, 3'h0, k[0], 4'h0, 4'(i)});
            end
        end
        // failed hash flags an error and leaves the last result in place
        sha_fail_req <= 1'b1;
        wr(9'h060, 16'h3600);
        repeat (T_SHA + 4) @(posedge clk_sys);
        wait_idle();
        sha_fail_req <= 1'b0;
        rd(9'h061, v);
        chk(v, 16'h0004);
        rd(9'h0C0, v);
        chk(v, 16'hC100);
        // mid-run reset brings protection back
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(9'h061, v);
        chk(v, 16'h00F9);
        conclude();
    end
endmodule
`default_nettype wire

// ---- hw/wpla_busy_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, busy while nonzero
module wpla_busy_timer #(
    parameter int W = 20
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    always_comb
    begin
        cnt_d = cnt_q;
        if (load)
            cnt_d = count;
        else if (cnt_q != '0)
            cnt_d = cnt_q - 1'b1;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
    assign busy = (cnt_q != '0);
    assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ---- hw/wpla_page_map.sv ----
`timescale 1ns/1ps
`default_nettype none
// maps a register page to its one-hot protect/lock group
module wpla_page_map
    import wpla_pkg::*;
(
    input  wire logic [3:0] page,
    input  wire logic       page_hi,
    output wpla_group_t     group
);
    logic [4:0] pg;
    assign pg = {page_hi, page};
    always_comb
    begin
        case (pg)
            5'h1A, 5'h1B, 5'h1E: group = 5'b00001; // [RL8]
            5'h01, 5'h02, 5'h03, 5'h04, 5'h0B, 5'h0D: group = 5'b00010; // [RL8]
            5'h18, 5'h19: group = 5'b00100; // [RL8]
            5'h1C: group = 5'b01000; // [RL8]
            5'h1D: group = 5'b10000; // [RL8]
            default: group = 5'b00000;
        endcase
    end
endmodule
`default_nettype wire

// ---- hw/wpla_pkg.sv ----
package wpla_pkg;
    typedef enum logic [1:0]
    {
        WPLA_IDLE   = 2'b00,
        WPLA_NV_RUN = 2'b01,
        WPLA_SHA_RUN = 2'b10
    } wpla_state_t;
    typedef logic [4:0] wpla_group_t;
endpackage

// ---- hw/wpla_regs.svh ----
`ifndef WPLA_REGS_SVH
`define WPLA_REGS_SVH
`define WPLA_ADDR_COMMAND      9'h060
`define WPLA_ADDR_PROT_STATUS  9'h061
`define WPLA_ADDR_LOCK_STATE   9'h07F
`define WPLA_ADDR_SHA_FIRST    9'h0C0
`define WPLA_ADDR_SHA_CHAL_END 9'h0C9
`define WPLA_ADDR_SHA_LAST     9'h0CF
`define WPLA_BIT_GLOBAL        0
`define WPLA_BIT_NV_BUSY       1
`define WPLA_BIT_NV_ERROR      2
`define WPLA_BIT_PAGE_LO       3
`define WPLA_BIT_PAGE_HI       7
`define WPLA_BIT_CHG_OFF       8
`define WPLA_BIT_DIS_OFF       9
`define WPLA_CMD_LOCK_OP       8'h6A
`define WPLA_CMD_MAC_ID        16'h3500
`define WPLA_CMD_MAC_NOID      16'h3600
`define WPLA_CMD_FULL_RESET    16'h000F
`define WPLA_PROT_RESET        16'h00F9
`define WPLA_T_UPDATE_US       1000
`define WPLA_T_SHA_US          100
`define WPLA_CLK_MHZ           40
`endif

// ---- hw/wpla_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wpla_regs.svh"
// Overview of operation
// (RL1) Global write protect is set after reset; no write lands until disabled.
// (RL2) Page write accepted only with global and its group protect both clear.
// (RL3) Protect bits change only after same value written twice back to back.
// (RL4) One double write updates all protect bits together; 0000h clears all.
// (RL5) Status layout: global D0, busy D1, error D2, groups D3-D7, fet D8-D9.
// (RL6) Global set protects every page; clear lets group bits decide.
// (RL7) Group protect bits update only while global protect is zero.
// (RL8) Groups cover pages 1A/1B/1E, 01-04/0B/0D, 18/19, 1C, 1D; locks too.
// (RL9) With override enabled, force-off bits hold the matching fet off.
// (RL10) Force-off bits are writable only with protection disabled.
// (RL11) Busy is zero at reset, set by a nonvolatile command, clears when done.
// (RL12) Error sets on failed command or full reset, stays until host clears.
// (RL13) Host error clear works only with write protection disabled.
// (RL14) Command 6AXXh sets locks marked one in its low five bits.
// (RL15) A set lock blocks writes to its page group forever; here only until rst clears lock_q.
// (RL16) Host unlocks, clears error, locks, waits, checks, then reprotects.
// (RL17) Lock state at 07Fh shows five locks in D4-D0, not secret lock.
// (RL18) Hash block is secret, challenge and constants, id optionally inside.
// (RL19) Challenge at 0C0h-0C9h; 3500h/3600h put mac into 0C0h-0CFh.
// (RL20) Host waits hash time then compares mac itself.
// (RL21) Authentication outcome affects nothing else; secret never on bus.
// (RL22) Stored-pair method uses only the command without unique id.
// (RL23) Protected or locked locations still read back their contents.
// (RL24) No path exists to clear a lock bit once set; here rst clears lock_q.
// (RL25) Any other access between the two writes discards the pending first.
// (RL26) Update and hash durations are parameters; busy covers the full time.
module wpla_top
    import wpla_pkg::*;
#(
    parameter int T_UPDATE_CYC = `WPLA_T_UPDATE_US * `WPLA_CLK_MHZ,
    parameter int T_SHA_CYC    = `WPLA_T_SHA_US * `WPLA_CLK_MHZ
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [8:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    output logic [15:0]       reg_rdata,
    output logic              page_wr_en,
    input  wire logic         override_enable_cfg,
    input  wire logic         nv_fail,
    input  wire logic         sha_done,
    input  wire logic         sha_fail,
    input  wire logic [255:0] sha_mac,
    output logic              sha_start,
    output logic              sha_with_id,
    output logic              discharge_fet_off,
    output logic              charge_fet_off
);
    localparam int TW = 20;

    logic              global_protect_q;
    logic              global_protect_d;
    wpla_group_t       page_group_protect_q;
    wpla_group_t       page_group_protect_d;
    wpla_group_t       lock_q;
    wpla_group_t       lock_d;
    logic              discharge_force_off_q;
    logic              discharge_force_off_d;
    logic              charge_force_off_q;
    logic              charge_force_off_d;
    logic              nonvolatile_error_q;
    logic              nonvolatile_error_d;
    logic              pend_valid_q;
    logic              pend_valid_d;
    logic [15:0]       pend_val_q;
    logic [15:0]       pend_val_d;
    wpla_state_t       state_q;
    wpla_state_t       state_d;
    wpla_group_t       lock_req_q;
    wpla_group_t       lock_req_d;
    logic              sha_start_q;
    logic              sha_start_d;
    logic              sha_with_id_q;
    logic              sha_with_id_d;
    logic [15:0]       sha_mem_q [0:15];
    logic [15:0]       sha_mem_d [0:15];
    logic [15:0]       rdata_q;
    logic [15:0]       rdata_d;

    wpla_group_t       wr_group;
    logic              timer_load;
    logic              timer_busy;
    logic              timer_done;
    logic [TW-1:0]     timer_count;
    logic              prot_unlocked;
    logic              is_prot;
    logic              is_cmd;
    logic              is_sha;
    logic              any_acc;
    logic [15:0]       stat_word;

    function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    wpla_page_map u_map (
        .page    (reg_addr[7:4]),
        .page_hi (reg_addr[8]),
        .group   (wr_group)
    );

    // one timer for lock updates and hashes; they never overlap
    wpla_busy_timer #(.W(TW)) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (timer_load),
        .count   (timer_count),
        .busy    (timer_busy),
        .done    (timer_done)
    );

    assign is_prot       = reg_addr == `WPLA_ADDR_PROT_STATUS;
    assign is_cmd        = reg_addr == `WPLA_ADDR_COMMAND;
    assign is_sha        = in_range(reg_addr, `WPLA_ADDR_SHA_FIRST, `WPLA_ADDR_SHA_LAST);
    assign any_acc       = reg_wr | reg_rd;
    // protection is disabled only with global and every group bit clear
    assign prot_unlocked = !global_protect_q && (page_group_protect_q == '0);

    // [RL2] [RL6] [RL15] gate for page writes outside this block
    // pages outside every group need only global clear
    assign page_wr_en = reg_wr && !global_protect_q
                        && ((wr_group & (page_group_protect_q | lock_q)) == '0);

    // undefined high bits read as zero
    assign stat_word = {6'h00, discharge_force_off_q, charge_force_off_q,
                        page_group_protect_q, nonvolatile_error_q, timer_busy,
                        global_protect_q}; // [RL5] [RL11]

    always_comb
    begin
        global_protect_d      = global_protect_q;
        page_group_protect_d  = page_group_protect_q;
        lock_d                = lock_q;
        discharge_force_off_d = discharge_force_off_q;
        charge_force_off_d    = charge_force_off_q;
        nonvolatile_error_d   = nonvolatile_error_q;
        pend_valid_d          = pend_valid_q;
        pend_val_d            = pend_val_q;
        state_d               = state_q;
        lock_req_d            = lock_req_q;
        sha_start_d           = 1'b0;
        sha_with_id_d         = sha_with_id_q;
        timer_load            = 1'b0;
        timer_count           = '0;
        for (int i = 0; i < 16; i++)
            sha_mem_d[i] = sha_mem_q[i];

        // idle cycles keep a pending first write; any other access drops it
        if (any_acc && !is_prot)
            pend_valid_d = 1'b0; // [RL25]

        if (reg_wr && is_prot)
        begin
            // error clear on a single write while unlocked
            if (prot_unlocked && !reg_wdata[`WPLA_BIT_NV_ERROR])
                nonvolatile_error_d = 1'b0; // [RL13]
            if (prot_unlocked)
            begin
                discharge_force_off_d = reg_wdata[`WPLA_BIT_DIS_OFF]; // [RL10]
                charge_force_off_d    = reg_wdata[`WPLA_BIT_CHG_OFF]; // [RL10]
            end
            if (pend_valid_q && pend_val_q == reg_wdata) // [RL3]
            begin
                pend_valid_d     = 1'b0;
                global_protect_d = reg_wdata[`WPLA_BIT_GLOBAL]; // [RL4]
                // group bits move only while global is clear now or becomes clear
                if (!global_protect_q || !reg_wdata[`WPLA_BIT_GLOBAL]) // [RL7]
                    page_group_protect_d = reg_wdata[`WPLA_BIT_PAGE_HI:`WPLA_BIT_PAGE_LO];
            end
            else
            begin
                pend_valid_d = 1'b1;
                pend_val_d   = reg_wdata;
            end
        end
        else if (reg_rd && is_prot)
            pend_valid_d = 1'b0; // [RL25]

        // challenge words land only while global protect is clear and idle
        if (reg_wr && is_sha && !global_protect_q && state_q == WPLA_IDLE
            && in_range(reg_addr, `WPLA_ADDR_SHA_FIRST, `WPLA_ADDR_SHA_CHAL_END))
            sha_mem_d[reg_addr[3:0]] = reg_wdata; // [RL19]

        case (state_q)
            WPLA_IDLE:
            begin
                // commands arriving while busy are dropped, not queued
                if (reg_wr && is_cmd && !global_protect_q)
                begin
                    if (reg_wdata[15:8] == `WPLA_CMD_LOCK_OP)
                    begin
                        lock_req_d  = reg_wdata[4:0]; // [RL14]
                        timer_load  = 1'b1;
                        timer_count = TW'(T_UPDATE_CYC); // [RL26]
                        state_d     = WPLA_NV_RUN; // [RL11]
                    end
                    else if (reg_wdata == `WPLA_CMD_MAC_ID || reg_wdata == `WPLA_CMD_MAC_NOID)
                    begin
                        sha_with_id_d = (reg_wdata == `WPLA_CMD_MAC_ID); // [RL18]
                        sha_start_d   = 1'b1;
                        timer_load    = 1'b1;
                        timer_count   = TW'(T_SHA_CYC); // [RL26]
                        state_d       = WPLA_SHA_RUN;
                    end
                    else if (reg_wdata == `WPLA_CMD_FULL_RESET)
                        nonvolatile_error_d = 1'b1; // [RL12]
                end
            end
            WPLA_NV_RUN:
            begin
                if (timer_done)
                begin
                    if (nv_fail)
                        nonvolatile_error_d = 1'b1; // [RL12]
                    else
                        lock_d = lock_q | lock_req_q; // [RL14] [RL24]
                    state_d = WPLA_IDLE;
                end
            end
            WPLA_SHA_RUN:
            begin
                if (timer_done)
                begin
                    // late or failed core result flags an error, nothing else
                    if (sha_fail || !sha_done)
                        nonvolatile_error_d = 1'b1; // [RL12] [RL21]
                    else
                        for (int i = 0; i < 16; i++)
                            sha_mem_d[i] = sha_mac[16*i +: 16]; // [RL19]
                    state_d = WPLA_IDLE;
                end
            end
            default: state_d = WPLA_IDLE;
        endcase

        // unmapped reads give zero; the secret has no read path
        rdata_d = 16'h0000;
        if (reg_rd)
        begin
            if (is_prot)
                rdata_d = stat_word; // [RL23]
            else if (reg_addr == `WPLA_ADDR_LOCK_STATE)
                rdata_d = {11'h000, lock_q}; // [RL17]
            else if (is_sha)
                rdata_d = sha_mem_q[reg_addr[3:0]]; // [RL21] [RL23]
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            global_protect_q      <= 1'b1; // [RL1]
            page_group_protect_q  <= 5'h1F;
            // locks restart clear: this block has no backing store
            lock_q                <= 5'h00;
            discharge_force_off_q <= 1'b0;
            charge_force_off_q    <= 1'b0;
            nonvolatile_error_q   <= 1'b0;
            pend_valid_q          <= 1'b0;
            pend_val_q            <= 16'h0000;
            state_q               <= WPLA_IDLE;
            lock_req_q            <= 5'h00;
            sha_start_q           <= 1'b0;
            sha_with_id_q         <= 1'b0;
            rdata_q               <= 16'h0000;
            for (int i = 0; i < 16; i++)
                sha_mem_q[i] <= 16'h0000;
        end
        else
        begin
            global_protect_q      <= global_protect_d;
            page_group_protect_q  <= page_group_protect_d;
            lock_q                <= lock_d;
            discharge_force_off_q <= discharge_force_off_d;
            charge_force_off_q    <= charge_force_off_d;
            nonvolatile_error_q   <= nonvolatile_error_d;
            pend_valid_q          <= pend_valid_d;
            pend_val_q            <= pend_val_d;
            state_q               <= state_d;
            lock_req_q            <= lock_req_d;
            sha_start_q           <= sha_start_d;
            sha_with_id_q         <= sha_with_id_d;
            rdata_q               <= rdata_d;
            for (int i = 0; i < 16; i++)
                sha_mem_q[i] <= sha_mem_d[i];
        end
    end

    assign reg_rdata         = rdata_q;
    assign sha_start         = sha_start_q;
    assign sha_with_id       = sha_with_id_q;
    assign discharge_fet_off = override_enable_cfg & discharge_force_off_q; // [RL9]
    assign charge_fet_off    = override_enable_cfg & charge_force_off_q; // [RL9]
endmodule
`default_nettype wire
